// File: cam_map.svh
// Constants of the conversion alarm monitor: field positions, reset values, codes.
// Assumes one clock clk_sys at 40 MHz and conversion-end events from the converter core.
`ifndef CAM_MAP_SVH
`define CAM_MAP_SVH
`define CAM_CODE_W 18
`define CAM_HYST_W 8
`define CAM_PIN_FN_ALARM 2'h1
`define CAM_FLAG_IN_HI 0
`define CAM_FLAG_IN_LO 1
`define CAM_FLAG_SUP_HI 2
`define CAM_FLAG_SUP_LO 3
`define CAM_NFLAGS 4
`define CAM_FLAGS_RST 4'h0
`endif

// File: cam_pkg.sv
// Types of the conversion alarm monitor.
// Assumes cam_map.svh supplies widths.
`include "cam_map.svh"
package cam_pkg;
  typedef logic [`CAM_CODE_W-1:0] cam_code_t;
  typedef logic [`CAM_NFLAGS-1:0] cam_flags_t;
  typedef struct packed {
    cam_flags_t active;
    cam_flags_t tripped;
  } cam_alarm_s;
endpackage : cam_pkg

// File: cam_hyst_cmp.sv
// One hysteresis comparator: sets past a threshold, releases once back beyond it by more than the margin.
// Assumes code and settings are stable on the cycle conv_done is high.
`timescale 1ns/1ps
module cam_hyst_cmp #(
  parameter int CW = 18,
  parameter int HW = 8,
  parameter bit IS_HIGH = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic conv_done,
  input wire logic [CW-1:0] code,
  input wire logic [CW-1:0] thresh,
  input wire logic [HW-1:0] hyst,
  output logic alarm
);
  logic alarm_reg;
  logic alarm_next;
  logic [CW+1:0] lim;
  // Widened so T+H+1 cannot wrap and a T-H-1 below zero sets the top bit
  always_comb begin
    lim = '0;
    alarm_next = alarm_reg;
    if (IS_HIGH) begin
      lim = {2'b00, thresh} - {{(CW+2-HW){1'b0}}, hyst} - {{(CW+1){1'b0}}, 1'b1};
      if ({2'b00, code} > {2'b00, thresh}) alarm_next = 1'b1;
      else if (!lim[CW+1] && ({2'b00, code} <= lim)) alarm_next = 1'b0;
    end else begin
      lim = {2'b00, thresh} + {{(CW+2-HW){1'b0}}, hyst} + {{(CW+1){1'b0}}, 1'b1};
      if (code < thresh) alarm_next = 1'b1;
      else if ({2'b00, code} >= lim) alarm_next = 1'b0;
    end
  end
  // State only moves at conversion end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) alarm_reg <= 1'b0;
    else if (conv_done) alarm_reg <= alarm_next;
  end
  assign alarm = alarm_reg;
endmodule : cam_hyst_cmp

// File: cam_alarm_top.sv
// Alarm monitor of an 18-bit converter: input thresholds, supply alarms, flags, pin.
// Assumes conv_done and flag_read are one-cycle pulses from logic on clk_sys;
// supply comparator outputs and chip-select are asynchronous and are synchronised here.
`timescale 1ns/1ps
`include "cam_map.svh"
module cam_alarm_top #(
  parameter int CODE_W = `CAM_CODE_W,
  parameter int HYST_W = `CAM_HYST_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic conv_done,
  input wire cam_pkg::cam_code_t conv_code,
  input wire cam_pkg::cam_code_t high_thresh,
  input wire cam_pkg::cam_code_t low_thresh,
  input wire logic [HYST_W-1:0] hysteresis,
  input wire logic supply_hi_cmp,
  input wire logic supply_lo_cmp,
  input wire logic input_alarm_disable,
  input wire logic supply_alarm_disable,
  input wire logic [1:0] second_output_pin_function,
  input wire logic other_pin_value,
  input wire logic [`CAM_NFLAGS-1:0] append_select,
  input wire logic flag_read,
  input wire logic convert_start_chip_select,
  output cam_pkg::cam_alarm_s alarm_flags,
  output logic [`CAM_NFLAGS-1:0] append_bits,
  output logic append_valid,
  output logic frame_active,
  output logic multi_function_output_pin
);
  import cam_pkg::*;

  logic in_hi;
  logic in_lo;
  logic [1:0] sup_hi_sync;
  logic [1:0] sup_lo_sync;
  logic [1:0] cs_sync;
  logic cs_d_reg;
  cam_flags_t raw;
  cam_flags_t en;
  cam_flags_t act_reg, act_next;
  cam_flags_t trip_reg, trip_next;
  logic pin_reg, pin_next;
  logic frame_reg, frame_next;
  logic [`CAM_NFLAGS-1:0] app_reg, app_next;
  logic app_v_reg, app_v_next;
  logic in_hi_c;
  logic in_lo_c;

  // Unsigned compares keep bipolar and unipolar ranges the same
  cam_hyst_cmp #(.CW(CODE_W), .HW(HYST_W), .IS_HIGH(1'b1)) u_hi (
    .clk_sys(clk_sys), .rstn(rstn), .conv_done(conv_done), .code(conv_code),
    .thresh(high_thresh), .hyst(hysteresis), .alarm(in_hi));
  cam_hyst_cmp #(.CW(CODE_W), .HW(HYST_W), .IS_HIGH(1'b0)) u_lo (
    .clk_sys(clk_sys), .rstn(rstn), .conv_done(conv_done), .code(conv_code),
    .thresh(low_thresh), .hyst(hysteresis), .alarm(in_lo));

  // Two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sup_hi_sync <= 2'h0;
      sup_lo_sync <= 2'h0;
      cs_sync <= 2'h3;
      cs_d_reg <= 1'b1;
    end else begin
      sup_hi_sync <= {sup_hi_sync[0], supply_hi_cmp};
      sup_lo_sync <= {sup_lo_sync[0], supply_lo_cmp};
      cs_sync <= {cs_sync[0], convert_start_chip_select};
      cs_d_reg <= cs_sync[1];
    end
  end

  // Hysteresis state is one cycle behind conv_done, so recompute the new value here
  always_comb begin
    in_hi_c = in_hi;
    in_lo_c = in_lo;
    if ({2'b00, conv_code} > {2'b00, high_thresh}) in_hi_c = 1'b1;
    else if ({2'b00, conv_code} + {{(CODE_W+2-HYST_W){1'b0}}, hysteresis} + 20'h0_0001
             <= {2'b00, high_thresh}) in_hi_c = 1'b0;
    if (conv_code < low_thresh) in_lo_c = 1'b1;
    else if ({2'b00, conv_code} >= {2'b00, low_thresh}
             + {{(CODE_W+2-HYST_W){1'b0}}, hysteresis} + 20'h0_0001) in_lo_c = 1'b0;
  end

  // Source conditions and their enables
  always_comb begin
    raw = `CAM_FLAGS_RST;
    raw[`CAM_FLAG_IN_HI] = in_hi_c;
    raw[`CAM_FLAG_IN_LO] = in_lo_c;
    raw[`CAM_FLAG_SUP_HI] = sup_hi_sync[1];
    raw[`CAM_FLAG_SUP_LO] = sup_lo_sync[1];
    en = {{2{!supply_alarm_disable}}, {2{!input_alarm_disable}}};
  end

  // Flag update; trigger beats a clearing read in the same cycle
  always_comb begin
    act_next = act_reg;
    trip_next = trip_reg;
    if (flag_read) trip_next = `CAM_FLAGS_RST;
    if (conv_done) begin
      act_next = raw & en;
      trip_next = trip_next | (raw & en);
    end
  end

  // Pin, frame tracking and append word
  always_comb begin
    pin_next = other_pin_value;
    if (second_output_pin_function == `CAM_PIN_FN_ALARM) begin
      pin_next = |act_next;
    end
    frame_next = !cs_sync[1];
    app_next = app_reg;
    app_v_next = 1'b0;
    if (cs_d_reg && !cs_sync[1]) begin
      // Latched at frame start so it reflects the prior conversion
      app_next = (act_reg | trip_reg) & append_select;
      app_v_next = 1'b1;
    end
  end

  // Register stage only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      act_reg <= `CAM_FLAGS_RST;
      trip_reg <= `CAM_FLAGS_RST;
      pin_reg <= 1'b0;
      frame_reg <= 1'b0;
      app_reg <= `CAM_FLAGS_RST;
      app_v_reg <= 1'b0;
    end else begin
      act_reg <= act_next;
      trip_reg <= trip_next;
      pin_reg <= pin_next;
      frame_reg <= frame_next;
      app_reg <= app_next;
      app_v_reg <= app_v_next;
    end
  end

  assign alarm_flags = '{active: act_reg, tripped: trip_reg};
  assign append_bits = app_reg;
  assign append_valid = app_v_reg;
  assign frame_active = frame_reg;
  assign multi_function_output_pin = pin_reg;

  // Checks
  a_active_rebuild: assert property (@(posedge clk_sys) disable iff (!rstn)
    conv_done |=> act_reg == $past(raw & en)) else $error("active flags not rebuilt");
  a_trip_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!flag_read && !conv_done) |=> trip_reg == $past(trip_reg)) else $error("tripped moved");
  a_trip_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    (flag_read && !conv_done) |=> trip_reg == 4'h0) else $error("read did not clear");
  a_set_wins: assert property (@(posedge clk_sys) disable iff (!rstn)
    (flag_read && conv_done) |=> trip_reg == act_reg) else $error("trigger lost on read");
  a_trip_covers: assert property (@(posedge clk_sys) disable iff (!rstn)
    conv_done |=> (act_reg & ~trip_reg) == 4'h0) else $error("active without tripped");
  a_disable_in: assert property (@(posedge clk_sys) disable iff (!rstn)
    (conv_done && input_alarm_disable) |=> act_reg[1:0] == 2'h0) else $error("input not off");
  a_pin_alarm: assert property (@(posedge clk_sys) disable iff (!rstn)
    (second_output_pin_function == 2'h1) |=> pin_reg == |act_reg) else $error("pin not OR");
  a_pin_other: assert property (@(posedge clk_sys) disable iff (!rstn)
    (second_output_pin_function != 2'h1) |=> pin_reg == $past(other_pin_value))
    else $error("pin function wrong");
  a_hi_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    (conv_done && !input_alarm_disable && conv_code > high_thresh) |=> act_reg[0])
    else $error("high alarm missed");
  a_lo_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    (conv_done && !input_alarm_disable && conv_code < low_thresh) |=> act_reg[1])
    else $error("low alarm missed");
  a_append_once: assert property (@(posedge clk_sys) disable iff (!rstn)
    app_v_reg |=> !app_v_reg) else $error("append valid too long");
  c_hi_trip: cover property (@(posedge clk_sys) disable iff (!rstn) conv_done ##1 act_reg[0]);
  c_read_clear: cover property (@(posedge clk_sys) disable iff (!rstn)
    (trip_reg != 4'h0 && flag_read) ##1 trip_reg == 4'h0);
  c_frame: cover property (@(posedge clk_sys) disable iff (!rstn) app_v_reg && app_reg != 4'h0);
endmodule : cam_alarm_top

// File: cam_host_model.sv
// Host side model: opens serial frames on chip-select, captures appended flags.
// Assumes the bench raises go for one cycle; chip-select idles high between frames.
`timescale 1ns/1ps
module cam_host_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic append_valid,
  input wire logic [3:0] append_bits,
  input wire logic frame_active,
  output logic convert_start_chip_select,
  output logic [3:0] got_bits,
  output logic got_fa
);
  initial begin
    convert_start_chip_select = 1'b1;
    got_bits = 4'h0;
    got_fa = 1'b0;
  end
  // Frame of eight cycles, long enough for the synchroniser and load
  // Go is sampled on the rising edge, away from the falling edge the bench drives it on
  always @(posedge clk_sys) begin
    if (go === 1'b1) begin
      @(negedge clk_sys);
      convert_start_chip_select <= 1'b0;
      repeat (8) @(negedge clk_sys);
      convert_start_chip_select <= 1'b1;
    end
  end
  // Capture loaded word and frame level as the host would see them
  always @(posedge clk_sys) begin
    if (append_valid === 1'b1) got_bits <= append_bits;
    if (frame_active === 1'b1) got_fa <= 1'b1;
  end
endmodule : cam_host_model

// File: conversion_alarm_monitor_tb.sv
// Self-checking bench of the alarm monitor: conversions, flag reads, supply, frames.
// Assumes cam_alarm_top and cam_host_model compiled before this file.
`timescale 1ns/1ps
module conversion_alarm_monitor_tb;
  import cam_pkg::*;
  logic clk_sys = 0, rstn = 0, conv_done = 0, flag_read = 0, go = 0;
  logic sup_hi = 0, sup_lo = 0, in_dis = 0, sup_dis = 0, other = 0;
  logic [1:0] pin_fn = 2'h1;
  logic [3:0] sel = 4'hf;
  cam_code_t code = 18'h0_0000;
  cam_alarm_s flags;
  logic [3:0] abits, got_bits;
  logic avalid, fa, pin, cs, got_fa;
  int miscompares = 0, samples_checked = 0;
  cam_alarm_top cam_alarm_top_inst (.clk_sys(clk_sys), .rstn(rstn), .conv_done(conv_done),
    .conv_code(code), .high_thresh(18'd1000), .low_thresh(18'd100), .hysteresis(8'd4),
    .supply_hi_cmp(sup_hi), .supply_lo_cmp(sup_lo), .input_alarm_disable(in_dis),
    .supply_alarm_disable(sup_dis), .second_output_pin_function(pin_fn),
    .other_pin_value(other), .append_select(sel), .flag_read(flag_read),
    .convert_start_chip_select(cs), .alarm_flags(flags), .append_bits(abits),
    .append_valid(avalid), .frame_active(fa), .multi_function_output_pin(pin));
  cam_host_model cam_host_model_inst (.clk_sys(clk_sys), .go(go), .append_valid(avalid),
    .append_bits(abits), .frame_active(fa), .convert_start_chip_select(cs),
    .got_bits(got_bits), .got_fa(got_fa));
  // 40 MHz clock
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One conversion end, optionally with a flag read in the same cycle
  task automatic conv(input int c, input logic rd);
    @(negedge clk_sys);
    code = c[17:0];
    conv_done = 1'b1;
    flag_read = rd;
    @(negedge clk_sys);
    conv_done = 1'b0;
    flag_read = 1'b0;
  endtask : conv
  task automatic rd_flags();
    @(negedge clk_sys);
    flag_read = 1'b1;
    @(negedge clk_sys);
    flag_read = 1'b0;
  endtask : rd_flags
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // Hang guard, well beyond the hundred or so cycles the tests need
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    chk("reset", 8'h00, flags);
    conv(500, 0); chk("mid", 8'h00, flags);
    conv(1000, 0); chk("at T", 8'h00, flags);
    conv(1001, 0); chk("hi set", 8'h11, flags);
    chk("pin hi", 8'h01, {7'h0, pin});
    conv(996, 0); chk("hi hold", 8'h11, flags);
    conv(995, 0); chk("hi rel", 8'h01, flags);
    chk("pin lo", 8'h00, {7'h0, pin});
    rd_flags(); chk("read", 8'h00, flags);
    $display("input high test done");
    conv(99, 0); chk("lo set", 8'h22, flags);
    conv(104, 0); chk("lo hold", 8'h22, flags);
    conv(105, 0); chk("lo rel", 8'h02, flags);
    conv(1001, 1); chk("read+set", 8'h11, flags);
    conv(500, 0); chk("trip kept", 8'h01, flags);
    rd_flags();
    $display("input low test done");
    sup_hi = 1'b1;
    sup_lo = 1'b1;
    repeat (4) @(negedge clk_sys);
    conv(500, 0); chk("supply", 8'hcc, flags);
    sup_dis = 1'b1;
    conv(500, 0); chk("sup dis act", 8'h00, {4'h0, flags.active});
    chk("pin dis", 8'h00, {7'h0, pin});
    in_dis = 1'b1;
    conv(1001, 0); chk("both dis", 8'h00, {7'h0, pin});
    sup_dis = 1'b0;
    in_dis = 1'b0;
    sup_hi = 1'b0;
    sup_lo = 1'b0;
    $display("supply test done");
    conv(1001, 0); pin_fn = 2'h0; other = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("pin other0", 8'h00, {7'h0, pin});
    other = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("pin other1", 8'h01, {7'h0, pin});
    pin_fn = 2'h1;
    rd_flags(); conv(1001, 0);
    @(negedge clk_sys); go = 1'b1;
    @(negedge clk_sys); go = 1'b0;
    repeat (12) @(negedge clk_sys);
    chk("append", 8'h01, {4'h0, got_bits});
    chk("frame", 8'h01, {7'h0, got_fa});
    sel = 4'he;
    @(negedge clk_sys); go = 1'b1;
    @(negedge clk_sys); go = 1'b0;
    repeat (12) @(negedge clk_sys);
    chk("append sel", 8'h00, {4'h0, got_bits});
    $display("frame test done");
    close_out();
  end
endmodule : conversion_alarm_monitor_tb
